// ### bench/gated_16bit_timer_counter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module gated_16bit_timer_counter_bench;
	import gtc_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, oth_rst = 1'b0, sleep = 1'b0, internal_oscillator = 1'b0;
	logic        gate_n = 1'b1, go = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rd_v;
	logic [3:0]  wstrb = '0;
	logic [7:0]  n_pulse = '0;
	logic [1:0]  rd_r, last_b;
	logic [15:0] cnt;
	wire logic   awready, wready, bvalid, arready, rvalid, irq, wake, lp_on, ext_pin, src_busy;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          mismatches = 0, n_checks = 0;
	logic [9:0]  regs [6] = '{IDX_INT_CTRL, IDX_IRQ_FLAGS, IDX_COUNT_LO, IDX_COUNT_HI,
		IDX_TIMER_CTRL, IDX_IRQ_ENABLES};

	always #2 clk = ~clk;

	gtc_timer i_dut (.CLK_SYS(clk), .RST_N(rst_n), .OTHER_RST(oth_rst), .SLEEP(sleep),
		.INTERNAL_OSCILLATOR_NO_CLKOUT(internal_oscillator), .EXT_CLOCK_PIN(ext_pin), .GATE_PIN_N(gate_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.IRQ(irq), .WAKE(wake), .LP_OSC_ON(lp_on));

	gtc_ext_source i_src (.clk(clk), .go(go), .n(n_pulse), .pin(ext_pin), .busy(src_busy));

	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic bad(input string m);
		mismatches++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) bad(m);
	endtask

	task automatic rng(input logic [15:0] g, input int lo, input int hi, input string m);
		logic ok;
		ok = (g >= lo) && (g <= hi);
		n_checks++;
		if (ok !== 1'b1) bad(m);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		int i;
		@(posedge clk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		last_b = bresp;
		bready <= 1'b0;
		if (i == 64) begin
			bad("write timeout");
			results();
		end
	endtask

	task automatic rd(input logic [9:0] idx, output logic [31:0] v, output logic [1:0] r);
		int i;
		@(posedge clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		if (i == 64) begin
			bad("read timeout");
			results();
		end
	endtask

	task automatic rdc(output logic [15:0] c);
		logic [31:0] h;
		logic [31:0] l;
		logic [1:0]  r;
		rd(IDX_COUNT_HI, h, r);
		rd(IDX_COUNT_LO, l, r);
		c = {h[7:0], l[7:0]};
	endtask

	task automatic pulse(input logic [7:0] n);
		int i;
		@(posedge clk);
		go <= 1'b1;
		n_pulse <= n;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 1000 && src_busy; i++) @(posedge clk);
		if (i == 1000) begin
			bad("source timeout");
			results();
		end
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			rd(regs[k], rd_v, rd_r);
			chk(rd_v, 32'h0, "reset value");
		end
		rd(10'h000, rd_v, rd_r);
		chk(rd_v, 32'h0, "unmapped read data");
		chk({30'h0, rd_r}, {30'h0, RESP_SLVERR}, "unmapped read response");
		wr(10'h000, 8'h55);
		chk({30'h0, last_b}, {30'h0, RESP_SLVERR}, "unmapped write response");
		wr(IDX_TIMER_CTRL, 8'hde);
		chk({30'h0, last_b}, {30'h0, RESP_OKAY}, "write response");
		rd(IDX_TIMER_CTRL, rd_v, rd_r);
		chk(rd_v, 32'h5e, "control top bit");
		wr(IDX_COUNT_HI, 8'h12);
		wr(IDX_COUNT_LO, 8'h34);
		wr(IDX_IRQ_FLAGS, 8'h01);
		wr(IDX_INT_CTRL, 8'hc0);
		@(posedge clk) oth_rst <= 1'b1;
		@(posedge clk) oth_rst <= 1'b0;
		rdc(cnt);
		chk(cnt, 16'h1234, "count kept over other reset");
		rd(IDX_TIMER_CTRL, rd_v, rd_r);
		chk(rd_v, 32'h5e, "control kept over other reset");
		rd(IDX_IRQ_FLAGS, rd_v, rd_r);
		chk(rd_v, 32'h0, "flag cleared by other reset");
		repeat (4) @(posedge clk);
		chk(lp_on, 1'b0, "lp osc without internal osc");
		internal_oscillator <= 1'b1;
		repeat (4) @(posedge clk);
		chk(lp_on, 1'b1, "lp osc on");
		internal_oscillator <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			wr(IDX_TIMER_CTRL, 8'h00);
			wr(IDX_COUNT_HI, 8'h00);
			wr(IDX_COUNT_LO, 8'h00);
			wr(IDX_TIMER_CTRL, 8'(16 * k + 1));
			repeat (512) @(posedge clk);
			wr(IDX_TIMER_CTRL, 8'h00);
			rdc(cnt);
			rng(cnt, (128 >> k) - 1, (128 >> k) + 2, "prescaled timer");
		end
		repeat (20) @(posedge clk);
		rdc(rd_v[15:0]);
		chk(rd_v[15:0], cnt, "stopped timer moved");
		wr(IDX_COUNT_HI, 8'h00);
		wr(IDX_COUNT_LO, 8'h00);
		wr(IDX_TIMER_CTRL, 8'h41);
		repeat (100) @(posedge clk);
		rdc(cnt);
		chk(cnt, 16'h0, "gate high counted");
		gate_n <= 1'b0;
		repeat (100) @(posedge clk);
		wr(IDX_TIMER_CTRL, 8'h00);
		gate_n <= 1'b1;
		rdc(cnt);
		rng(cnt, 20, 30, "gate low count");
		wr(IDX_COUNT_HI, 8'hff);
		wr(IDX_COUNT_LO, 8'hfe);
		wr(IDX_TIMER_CTRL, 8'h01);
		repeat (40) @(posedge clk);
		wr(IDX_TIMER_CTRL, 8'h00);
		rdc(cnt);
		rng(cnt, 1, 16, "wrap");
		rd(IDX_IRQ_FLAGS, rd_v, rd_r);
		chk(rd_v, 32'h1, "overflow flag");
		wr(IDX_IRQ_ENABLES, 8'h01);
		wr(IDX_INT_CTRL, 8'hc0);
		repeat (3) @(posedge clk);
		chk({irq, wake}, 2'b10, "irq on, wake off while stopped");
		wr(IDX_TIMER_CTRL, 8'h01);
		wr(IDX_INT_CTRL, 8'h40);
		repeat (3) @(posedge clk);
		chk({irq, wake}, 2'b01, "wake without global enable");
		wr(IDX_IRQ_FLAGS, 8'h00);
		repeat (3) @(posedge clk);
		chk({irq, wake}, 2'b00, "flag clear removes request");
		wr(IDX_TIMER_CTRL, 8'h00);
		wr(IDX_COUNT_HI, 8'h00);
		wr(IDX_COUNT_LO, 8'h00);
		wr(IDX_TIMER_CTRL, 8'h07);
		pulse(8'd8);
		rdc(cnt);
		chk(cnt, 16'd7, "async count, first rise skipped");
		wr(IDX_TIMER_CTRL, 8'h03);
		pulse(8'd8);
		rdc(cnt);
		chk(cnt, 16'd15, "synchronised count");
		sleep <= 1'b1;
		pulse(8'd4);
		rdc(cnt);
		chk(cnt, 16'd15, "sync counter ran in sleep");
		wr(IDX_TIMER_CTRL, 8'h01);
		repeat (40) @(posedge clk);
		rdc(cnt);
		chk(cnt, 16'd15, "timer ran in sleep");
		wr(IDX_TIMER_CTRL, 8'h00);
		wr(IDX_COUNT_HI, 8'hff);
		wr(IDX_COUNT_LO, 8'hfe);
		wr(IDX_TIMER_CTRL, 8'h07);
		pulse(8'd4);
		chk(wake, 1'b1, "wake on async overflow in sleep");
		rdc(cnt);
		chk(cnt, 16'h0001, "async count in sleep");
		sleep <= 1'b0;
		results();
	end
endmodule
`default_nettype wire

// ### bench/gtc_ext_source.sv
`timescale 1ns/10ps
`default_nettype none
module gtc_ext_source #(
	parameter int HALF = 6
) (
	input  wire logic       clk,  // system clock, paces the edges
	input  wire logic       go,   // start a burst
	input  wire logic [7:0] n,    // rising edges in the burst
	output logic            pin,  // external clock line
	output logic            busy  // burst in progress
);
	logic [8:0] left;
	int         ph;

	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end

	// line rests low between bursts, so each burst opens with a rise
	always @(posedge clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			left <= {n, 1'b0} - 9'h001;
			ph <= HALF;
			pin <= 1'b1;
		end else if (busy) begin
			if (ph != 0) begin
				ph <= ph - 1;
			end else begin
				ph <= HALF;
				left <= left - 9'h001;
				pin <= ~pin;
				busy <= (left != 9'h001);
			end
		end
	end
endmodule
`default_nettype wire

// ### design/gtc_pkg.sv
package gtc_pkg;

	// ----------------------------------------------------------------
	// register map (word index, byte address is index * 4)
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 12;
	localparam logic [9:0]  IDX_INT_CTRL    = 10'h00b;
	localparam logic [9:0]  IDX_IRQ_FLAGS   = 10'h00c;
	localparam logic [9:0]  IDX_COUNT_LO    = 10'h00e;
	localparam logic [9:0]  IDX_COUNT_HI    = 10'h00f;
	localparam logic [9:0]  IDX_TIMER_CTRL  = 10'h010;
	localparam logic [9:0]  IDX_IRQ_ENABLES = 10'h08c;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          POS_OVF_FLAG    = 0;
	localparam int          POS_OVF_IE      = 0;
	localparam int          POS_PERIPH_IE   = 6;
	localparam int          POS_GLOBAL_IE   = 7;
	localparam logic [7:0]  RST_INT_CTRL    = 8'h00;
	localparam logic [6:0]  RST_TIMER_CTRL  = 7'h00;
	localparam logic [15:0] RST_COUNT       = 16'h0000;
	localparam logic [15:0] COUNT_MAX       = 16'hffff;
	localparam logic [2:0]  RST_PRESCALE    = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          OSC_PER_INSTR   = 4;
	localparam logic [1:0]  INSTR_DIV_LAST  = 2'(OSC_PER_INSTR - 1);

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		GTC_DIV1 = 2'h0,
		GTC_DIV2 = 2'h1,
		GTC_DIV4 = 2'h2,
		GTC_DIV8 = 2'h3
	} gtc_prescale_t;

	// timer_control, bit 7 unimplemented
	typedef struct packed {
		logic          gate_enable;
		gtc_prescale_t prescale_select;
		logic          lp_osc_enable;
		logic          sync_bypass;
		logic          clock_source_select;
		logic          run_control;
	} gtc_ctrl_t;

endpackage

// ### design/gtc_timer.sv
// Summary of operation
// - count wraps FFFFh to 0000h, setting overflow flag
// - source select: external rising edge or osc/4
// - external edge counts only after a falling edge
// - sync bypass chooses unsynchronised external counting
// - gate enable: count only while gate pin low
// - run control starts and stops counting
// - prescaler divides by 1, 2, 4 or 8
// - prescaler hidden, cleared on count byte write
// - low-power oscillator only with internal oscillator
// - oscillator on forces pin directions and reads; no pins are forced here, only LP_OSC_ON is raised
// - asynchronous counter runs and wakes during sleep
// - sleep stops timer and synchronised counter modes
// - wake on overflow with run and enables
// - interrupt needs all three enables; software clears
// - count byte reads are always valid values
// - control top bit reads zero, ignores writes
// - power-on clears registers; other resets keep count
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer
	import gtc_pkg::*;
(
	input  wire logic                      CLK_SYS,          // 250 MHz system clock
	input  wire logic                      RST_N,            // power-on reset, async
	input  wire logic                      OTHER_RST,        // other reset, sync pulse
	input  wire logic                      SLEEP,            // core is sleeping
	input  wire logic                      INTERNAL_OSCILLATOR_NO_CLKOUT, // internal osc w/o clock out
	input  wire logic                      EXT_CLOCK_PIN,    // external clock / osc pin
	input  wire logic                      GATE_PIN_N,       // gate pin, active low
	input  wire logic [gtc_pkg::ADDR_W-1:0] S_AXI_AWADDR,    // write address
	input  wire logic                      S_AXI_AWVALID,    // write address valid
	output logic                           S_AXI_AWREADY,    // write address ready
	input  wire logic [31:0]               S_AXI_WDATA,      // write data
	input  wire logic [3:0]                S_AXI_WSTRB,      // write strobes
	input  wire logic                      S_AXI_WVALID,     // write data valid
	output logic                           S_AXI_WREADY,     // write data ready
	output logic [1:0]                     S_AXI_BRESP,      // write response
	output logic                           S_AXI_BVALID,     // write response valid
	input  wire logic                      S_AXI_BREADY,     // write response ready
	input  wire logic [gtc_pkg::ADDR_W-1:0] S_AXI_ARADDR,    // read address
	input  wire logic                      S_AXI_ARVALID,    // read address valid
	output logic                           S_AXI_ARREADY,    // read address ready
	output logic [31:0]                    S_AXI_RDATA,      // read data
	output logic [1:0]                     S_AXI_RRESP,      // read response
	output logic                           S_AXI_RVALID,     // read data valid
	input  wire logic                      S_AXI_RREADY,     // read data ready
	output logic                           IRQ,              // interrupt request to core
	output logic                           WAKE,             // wake request to core
	output logic                           LP_OSC_ON         // lp osc runs; no pins forced here
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	gtc_ctrl_t                 ctrl_q, ctrl_d;
	logic [7:0]                intc_q, intc_d;
	logic                      flag_q, flag_d;
	logic                      ie_q, ie_d;
	logic [15:0]               cnt_q, cnt_d;
	logic [2:0]                pre_q, pre_d;
	logic [1:0]                idiv_q;
	logic                      ext_s1_q, ext_s2_q, ext_prev_q, armed_q;
	logic                      gate_s1_q, gate_s2_q;
	logic                      tog_q, sy1_q, sy2_q, sy3_q;
	logic                      aw_full_q, w_full_q;
	logic [ADDR_W-1:0]         aw_addr_q;
	logic [7:0]                w_data_q;
	logic                      w_lane0_q;
	logic                      aw_full_d, w_full_d, bvalid_d, rvalid_d;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire        aw_take   = S_AXI_AWVALID & S_AXI_AWREADY;
	wire        w_take    = S_AXI_WVALID & S_AXI_WREADY;
	wire        ar_take   = S_AXI_ARVALID & S_AXI_ARREADY;
	wire        do_write  = aw_full_q & w_full_q & ~S_AXI_BVALID;
	wire [9:0]  wr_idx    = aw_addr_q[ADDR_W-1:2];
	wire [9:0]  rd_idx    = S_AXI_ARADDR[ADDR_W-1:2];
	wire        wr_en     = do_write & w_lane0_q;
	wire        wr_intc   = wr_en & (wr_idx == IDX_INT_CTRL);
	wire        wr_flags  = wr_en & (wr_idx == IDX_IRQ_FLAGS);
	wire        wr_lo     = wr_en & (wr_idx == IDX_COUNT_LO);
	wire        wr_hi     = wr_en & (wr_idx == IDX_COUNT_HI);
	wire        wr_ctrl   = wr_en & (wr_idx == IDX_TIMER_CTRL);
	wire        wr_ie     = wr_en & (wr_idx == IDX_IRQ_ENABLES);
	wire        wr_hit    = (wr_idx == IDX_INT_CTRL) | (wr_idx == IDX_IRQ_FLAGS)
	                      | (wr_idx == IDX_COUNT_LO) | (wr_idx == IDX_COUNT_HI)
	                      | (wr_idx == IDX_TIMER_CTRL) | (wr_idx == IDX_IRQ_ENABLES);
	wire        rd_hit    = (rd_idx == IDX_INT_CTRL) | (rd_idx == IDX_IRQ_FLAGS)
	                      | (rd_idx == IDX_COUNT_LO) | (rd_idx == IDX_COUNT_HI)
	                      | (rd_idx == IDX_TIMER_CTRL) | (rd_idx == IDX_IRQ_ENABLES);
	// single clock domain: the byte read is always a settled value
	wire [7:0]  rd_byte   = (rd_idx == IDX_INT_CTRL)    ? intc_q
	                      : (rd_idx == IDX_IRQ_FLAGS)   ? {7'h00, flag_q}
	                      : (rd_idx == IDX_COUNT_LO)    ? cnt_q[7:0]
	                      : (rd_idx == IDX_COUNT_HI)    ? cnt_q[15:8]
	                      : (rd_idx == IDX_TIMER_CTRL)  ? {1'b0, ctrl_q}
	                      : (rd_idx == IDX_IRQ_ENABLES) ? {7'h00, ie_q}
	                      : 8'h00;

	// ----------------------------------------------------------------
	// count enables and clock sources
	// ----------------------------------------------------------------
	wire        ext_sel   = ctrl_q.clock_source_select;
	wire        async_ext = ext_sel & ctrl_q.sync_bypass;
	wire        gate_ok   = ~ctrl_q.gate_enable | ~gate_s2_q;
	wire        sleep_ok  = ~SLEEP | async_ext;
	wire        cnt_en    = ctrl_q.run_control & gate_ok & sleep_ok;
	wire        itick     = (idiv_q == INSTR_DIV_LAST);
	wire        ext_fall  = ext_prev_q & ~ext_s2_q;
	wire        ext_rise  = ~ext_prev_q & ext_s2_q & armed_q;
	wire        src_pulse = cnt_en & (ext_sel ? ext_rise : itick);
	wire [2:0]  pre_mask  = (ctrl_q.prescale_select == GTC_DIV8) ? 3'h7
	                      : (ctrl_q.prescale_select == GTC_DIV4) ? 3'h3
	                      : (ctrl_q.prescale_select == GTC_DIV2) ? 3'h1
	                      : 3'h0;
	wire        pre_tick  = src_pulse & ((pre_q & pre_mask) == pre_mask);
	wire        sync_path = ext_sel & ~ctrl_q.sync_bypass;
	wire        sy_pulse  = sy2_q ^ sy3_q;
	wire        inc       = sync_path ? (sy_pulse & cnt_en) : pre_tick;
	wire        wrap      = inc & (cnt_q == COUNT_MAX);
	wire        lp_on     = ctrl_q.lp_osc_enable & INTERNAL_OSCILLATOR_NO_CLKOUT;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		if (inc) begin
			cnt_d = cnt_q + 16'h0001;
		end
		if (wr_lo) begin
			cnt_d[7:0] = w_data_q;
		end
		if (wr_hi) begin
			cnt_d[15:8] = w_data_q;
		end
	end

	always_comb begin
		pre_d = pre_q;
		if (wr_lo | wr_hi) begin
			pre_d = RST_PRESCALE;
		end else if (src_pulse) begin
			pre_d = pre_q + 3'h1;
		end
	end

	// hardware set wins over a software clear in the same cycle
	assign flag_d = wrap | (wr_flags ? w_data_q[POS_OVF_FLAG] : flag_q);
	assign ctrl_d = wr_ctrl ? gtc_ctrl_t'(w_data_q[6:0]) : ctrl_q;
	assign intc_d = wr_intc ? w_data_q : intc_q;
	assign ie_d   = wr_ie ? w_data_q[POS_OVF_IE] : ie_q;

	assign aw_full_d = (aw_full_q | aw_take) & ~do_write;
	assign w_full_d  = (w_full_q | w_take) & ~do_write;
	assign bvalid_d  = do_write | (S_AXI_BVALID & ~S_AXI_BREADY);
	assign rvalid_d  = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);

	// ----------------------------------------------------------------
	// registers kept over other resets
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= gtc_ctrl_t'(RST_TIMER_CTRL);
			cnt_q  <= RST_COUNT;
			pre_q  <= RST_PRESCALE;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q  <= cnt_d;
			pre_q  <= pre_d;
		end
	end

	// ----------------------------------------------------------------
	// registers cleared by other resets too, except int control bit 0
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			intc_q <= RST_INT_CTRL;
			flag_q <= 1'b0;
			ie_q   <= 1'b0;
		end else if (OTHER_RST) begin
			intc_q <= {RST_INT_CTRL[7:1], intc_q[0]};
			flag_q <= 1'b0;
			ie_q   <= 1'b0;
		end else begin
			intc_q <= intc_d;
			flag_q <= flag_d;
			ie_q   <= ie_d;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers, edge arming, instruction clock divider
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ext_s1_q   <= 1'b0;
			ext_s2_q   <= 1'b0;
			ext_prev_q <= 1'b0;
			gate_s1_q  <= 1'b1;
			gate_s2_q  <= 1'b1;
			armed_q    <= 1'b0;
			idiv_q     <= 2'h0;
		end else begin
			ext_s1_q   <= EXT_CLOCK_PIN;
			ext_s2_q   <= ext_s1_q;
			ext_prev_q <= ext_s2_q;
			gate_s1_q  <= GATE_PIN_N;
			gate_s2_q  <= gate_s1_q;
			armed_q    <= (armed_q | ext_fall) & ext_sel & ctrl_q.run_control;
			idiv_q     <= itick ? 2'h0 : idiv_q + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// synchronised counter path: toggle, two stages, edge pulse
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tog_q <= 1'b0;
			sy1_q <= 1'b0;
			sy2_q <= 1'b0;
			sy3_q <= 1'b0;
		end else begin
			tog_q <= tog_q ^ (pre_tick & sync_path);
			sy1_q <= tog_q;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// ----------------------------------------------------------------
	// outputs to core and pins
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			IRQ       <= 1'b0;
			WAKE      <= 1'b0;
			LP_OSC_ON <= 1'b0;
		end else begin
			IRQ       <= flag_q & ie_q & intc_q[POS_PERIPH_IE] & intc_q[POS_GLOBAL_IE];
			WAKE      <= ctrl_q.run_control & flag_q & ie_q & intc_q[POS_PERIPH_IE];
			LP_OSC_ON <= lp_on;
		end
	end

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			aw_addr_q     <= '0;
			w_data_q      <= 8'h00;
			w_lane0_q     <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= RESP_OKAY;
		end else begin
			aw_full_q     <= aw_full_d;
			w_full_q      <= w_full_d;
			S_AXI_AWREADY <= ~aw_full_d & ~bvalid_d;
			S_AXI_WREADY  <= ~w_full_d & ~bvalid_d;
			S_AXI_BVALID  <= bvalid_d;
			S_AXI_ARREADY <= ~rvalid_d;
			S_AXI_RVALID  <= rvalid_d;
			if (aw_take) begin
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (w_take) begin
				w_data_q  <= S_AXI_WDATA[7:0];
				w_lane0_q <= S_AXI_WSTRB[0];
			end
			if (do_write) begin
				S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (ar_take) begin
				S_AXI_RDATA <= {24'h000000, rd_byte};
				S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	wire no_cnt_wr = ~wr_lo & ~wr_hi;

	a_wrap_sets_flag: assert property (wrap && no_cnt_wr && !OTHER_RST
		|=> flag_q && cnt_q == 16'h0000)
		else $error("wrap did not clear count and set flag");
	a_internal_rate: assert property (!ext_sel && cnt_en
		&& ctrl_q.prescale_select == GTC_DIV1 |-> inc == itick)
		else $error("internal clock rate wrong");
	a_edge_armed: assert property (ext_sel && inc && !sync_path |-> armed_q)
		else $error("external edge counted before a falling edge");
	a_arm_cleared: assert property (!ctrl_q.run_control |=> !armed_q)
		else $error("edge arm kept while stopped");
	a_async_direct: assert property (async_ext
		&& ctrl_q.prescale_select == GTC_DIV1 |-> inc == (cnt_en && ext_rise))
		else $error("unsynchronised count not direct");
	a_sync_latency: assert property (pre_tick && sync_path
		##1 (sync_path && cnt_en) [*3] |-> inc)
		else $error("synchronised increment missing");
	a_gate_blocks: assert property (ctrl_q.gate_enable && gate_s2_q && no_cnt_wr
		|=> cnt_q == $past(cnt_q))
		else $error("count moved while gate high");
	a_stop_holds: assert property (!ctrl_q.run_control && no_cnt_wr
		|=> cnt_q == $past(cnt_q))
		else $error("count moved while stopped");
	a_div8_spacing: assert property (inc && !sync_path
		&& ctrl_q.prescale_select == GTC_DIV8 |-> $past(pre_q) == 3'h6 || pre_q == 3'h7)
		else $error("prescale by eight wrong");
	a_prescale_clear: assert property (wr_lo || wr_hi |=> pre_q == 3'h0)
		else $error("prescaler not cleared on count write");
	a_async_sleep: assert property (SLEEP && async_ext && inc && no_cnt_wr
		|=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("asynchronous count stalled in sleep");
	a_sleep_hold: assert property (SLEEP && !async_ext && no_cnt_wr
		|=> cnt_q == $past(cnt_q))
		else $error("count moved in sleep outside async mode");
	a_irq_gating: assert property (IRQ
		|-> $past(flag_q && ie_q && intc_q[7] && intc_q[6]))
		else $error("interrupt without all enables");
	a_flag_clear: assert property (wr_flags && !w_data_q[POS_OVF_FLAG] && !wrap
		|=> !flag_q)
		else $error("software clear of overflow flag lost");
	a_wake_req: assert property (ctrl_q.run_control && flag_q && ie_q && intc_q[6]
		&& $stable(ctrl_q) && !OTHER_RST |=> WAKE)
		else $error("wake request missing");
	a_ctrl_top_zero: assert property (ar_take && rd_idx == IDX_TIMER_CTRL
		|=> S_AXI_RDATA[7] == 1'b0)
		else $error("control top bit not zero");
	a_lp_osc_cond: assert property (LP_OSC_ON |-> $past(INTERNAL_OSCILLATOR_NO_CLKOUT))
		else $error("lp osc on without internal oscillator");
	a_lp_osc_on: assert property (ctrl_q.lp_osc_enable && INTERNAL_OSCILLATOR_NO_CLKOUT
		|=> LP_OSC_ON)
		else $error("lp osc not reported on");

	// ----------------------------------------------------------------
	// bus handshake checks
	// ----------------------------------------------------------------
	a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped before ready");
	a_rdata_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
		else $error("read data dropped before ready");
	a_busy_refuses: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write accepted before response taken");

	c_overflow: cover property (wrap);
	c_sleep_wake: cover property (SLEEP && async_ext && wrap);
	c_sync_count: cover property (sync_path && inc);
	c_irq_raised: cover property ($rose(IRQ));
	c_gated_count: cover property (ctrl_q.gate_enable && !gate_s2_q && inc);

endmodule
`default_nettype wire
